// file: verilog/afg_verb_responder.v
// Verb responder for the root node and the audio function group node.
// Assumes verbs arrive as node, verb and payload fields sampled at link clock edges.
`timescale 1ns/1ps
`include "afg_verb_map.vh"
module afg_verb_responder (
  input wire clk,
  input wire reset,
  input wire linkClk,
  input wire verbValid,
  input wire [7:0] verbNode,
  input wire [11:0] verbCode,
  input wire [7:0] verbPayload,
  output reg respValid,
  output reg [31:0] respData,
  output reg [1:0] actualPowerLevel,
  output reg [5:0] clockSelect
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ANSWER = 2'b10;

  wire linkRise;
  reg [1:0] validSync_reg;
  reg [7:0] nodeHold_reg;
  reg [11:0] codeHold_reg;
  reg [7:0] payloadHold_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] requestedPowerLevel_reg;
  reg [31:0] subsystemId_reg;
  reg [31:0] respData_next;

  afg_edge_sync linkEdge (
    .clk(clk),
    .reset(reset),
    .pinIn(linkClk),
    .pinLevel(),
    .risePulse(linkRise)
  );

  // Fields are captured once per rising link edge; the strobe gets a two-flop delay
  always @(posedge clk) begin
    if (reset) begin
      validSync_reg <= 2'b00;
      nodeHold_reg <= 8'h00;
      codeHold_reg <= 12'h000;
      payloadHold_reg <= 8'h00;
    end else begin
      validSync_reg <= {validSync_reg[0], verbValid};
      if (linkRise) begin
        nodeHold_reg <= verbNode;
        codeHold_reg <= verbCode;
        payloadHold_reg <= verbPayload;
      end
    end
  end

  function isPowerLegal;
    input [1:0] level;
    begin
      isPowerLegal = (level == `AFG_PWR_D0) || (level == `AFG_PWR_D3);
    end
  endfunction

  function [31:0] paramLookup;
    input rootNode;
    input [7:0] paramId;
    begin
      paramLookup = `AFG_RESP_ZERO; // RULE_16
      case (paramId)
        `AFG_PARAM_CHILD_COUNT:
          paramLookup = rootNode ? `AFG_ROOT_CHILD_COUNT : `AFG_GROUP_CHILD_COUNT; // RULE_01
        `AFG_PARAM_GROUP_TYPE: if (!rootNode) paramLookup = `AFG_GROUP_TYPE; // RULE_06
        `AFG_PARAM_GROUP_CAP: if (!rootNode) paramLookup = `AFG_GROUP_CAP; // RULE_07
        `AFG_PARAM_POWER_LEVELS: if (!rootNode) paramLookup = `AFG_POWER_LEVELS; // RULE_08
        `AFG_PARAM_LINK_CLK_CAPS: if (!rootNode) paramLookup = `AFG_LINK_CLK_CAPS; // RULE_10
        default: paramLookup = `AFG_RESP_ZERO;
      endcase
    end
  endfunction

  wire verbTaken = validSync_reg[1] && (state_reg == ST_IDLE);
  wire isRoot = nodeHold_reg == `AFG_NODE_ROOT;
  wire isGroup = nodeHold_reg == `AFG_NODE_GROUP;
  // The four byte verbs of each kind differ only in their two low bits
  wire isSsidSet = isGroup && ({codeHold_reg[11:2], 2'b00} == `AFG_VERB_SSID_WRITE0); // RULE_04
  wire isSsidGet = isGroup && ({codeHold_reg[11:2], 2'b00} == `AFG_VERB_SSID_READ0); // RULE_04

  always @* begin
    case (state_reg)
      ST_IDLE: state_next = verbTaken ? ST_ANSWER : ST_IDLE;
      ST_ANSWER: state_next = validSync_reg[1] ? ST_ANSWER : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Response word, reserved bits forced to zero
  always @* begin
    respData_next = `AFG_RESP_ZERO; // RULE_16
    if (isRoot && codeHold_reg == `AFG_VERB_GET_PARAM) begin
      respData_next = paramLookup(1'b1, payloadHold_reg); // RULE_01
    end else if (isRoot && codeHold_reg == `AFG_VERB_GET_CLK_ROOT) begin
      respData_next = {26'h000_0000, clockSelect}; // RULE_02 RULE_03
    end else if (isGroup) begin
      case (codeHold_reg) // RULE_04
        `AFG_VERB_GET_PARAM: respData_next = paramLookup(1'b0, payloadHold_reg); // RULE_05 RULE_09 RULE_11
        `AFG_VERB_GET_PWR:
          respData_next = `AFG_PWR_CLOCK_STOP_OK |
            {26'h000_0000, actualPowerLevel, 2'b00, requestedPowerLevel_reg}; // RULE_13 RULE_14
        `AFG_VERB_GET_CLK: respData_next = {26'h000_0000, clockSelect}; // RULE_02 RULE_03
        default: begin
          if (isSsidGet) begin
            respData_next = subsystemId_reg;
          end
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      respValid <= 1'b0;
      respData <= `AFG_RESP_ZERO;
      requestedPowerLevel_reg <= `AFG_PWR_RESET; // RULE_13
      actualPowerLevel <= `AFG_PWR_RESET; // RULE_14
      clockSelect <= `AFG_CLK_RESET; // RULE_02
      subsystemId_reg <= `AFG_SSID_RESET;
    end else begin
      state_reg <= state_next;
      respValid <= verbTaken;
      if (verbTaken) begin
        respData <= respData_next;
        if (isGroup && codeHold_reg == `AFG_VERB_SET_PWR) begin
          // Actual level follows at once: no slow power sequencing here
          if (isPowerLegal(payloadHold_reg[1:0])) begin // RULE_12 RULE_15
            requestedPowerLevel_reg <= payloadHold_reg[1:0];
            actualPowerLevel <= payloadHold_reg[1:0];
          end
        end
        if (isGroup && codeHold_reg == `AFG_VERB_SET_CLK) begin
          // Only the 96 and 48 MHz flags may ever be reported; one-hot required
          if ((payloadHold_reg[5:0] & ~`AFG_CLK_LEGAL) == 6'h00 &&
              (payloadHold_reg[`AFG_CLK_96_BIT] ^ payloadHold_reg[`AFG_CLK_48_BIT])) begin // RULE_03
            clockSelect <= payloadHold_reg[5:0];
          end
        end
        if (isSsidSet) begin
          case (codeHold_reg[1:0])
            2'd0: subsystemId_reg[7:0] <= payloadHold_reg;
            2'd1: subsystemId_reg[15:8] <= payloadHold_reg;
            2'd2: subsystemId_reg[23:16] <= payloadHold_reg;
            default: subsystemId_reg[31:24] <= payloadHold_reg;
          endcase
        end
      end
    end
  end
endmodule // afg_verb_responder

// file: verilog/afg_verb_map.vh
// Constants for the audio function group verb responder.
// Assumes a link front end that presents decoded node, verb and payload fields.
// Function
// [RULE_01] Root node reports exactly one subordinate node in the low byte.
// [RULE_02] Clock report sets the 96 MHz bit by default; other bits zero.
// [RULE_03] Clock report returns zero for the 192, 24, 12 and 6 MHz bits.
// [RULE_04] Group node decodes parameter, power, subsystem id and clock verbs.
// [RULE_05] Group child count reports first node 03h and total 07h.
// [RULE_06] Group type reports audio group kind 01h, unsolicited bit clear.
// [RULE_07] Group capability reports zero output latency, upper bits zero.
// [RULE_08] Power levels parameter sets extended low-power and clock-stop bits.
// [RULE_09] Power levels parameter sets D3 and D0, clears D2 and D1.
// [RULE_10] Link clock caps report codec clock locked to link clock.
// [RULE_11] Link clock caps set 96 and 48 MHz; others read zero.
// [RULE_12] Controller requests only D0 or D3; device accepts both.
// [RULE_13] Power read echoes last requested level; reset value is 11.
// [RULE_14] Power read reports actual level in bits 5:4; reset value 11.
// [RULE_15] Unsupported power encodings leave requested and actual level unchanged.
// [RULE_16] Reserved bits of every response always read zero.
`ifndef AFG_VERB_MAP_VH
`define AFG_VERB_MAP_VH
`define AFG_NODE_ROOT 8'h00
`define AFG_NODE_GROUP 8'h01
`define AFG_VERB_GET_PARAM 12'hF00
`define AFG_VERB_SET_PWR 12'h705
`define AFG_VERB_GET_PWR 12'hF05
`define AFG_VERB_SSID_WRITE0 12'h720
`define AFG_VERB_SSID_READ0 12'hF20
`define AFG_VERB_SET_CLK 12'h724
`define AFG_VERB_GET_CLK 12'hF24
`define AFG_VERB_GET_CLK_ROOT 12'hF37
`define AFG_PARAM_CHILD_COUNT 8'h04
`define AFG_PARAM_GROUP_TYPE 8'h05
`define AFG_PARAM_GROUP_CAP 8'h08
`define AFG_PARAM_POWER_LEVELS 8'h0F
`define AFG_PARAM_LINK_CLK_CAPS 8'h16
`define AFG_ROOT_CHILD_COUNT 32'h0001_0001
`define AFG_GROUP_CHILD_COUNT 32'h0003_0007
`define AFG_GROUP_TYPE 32'h0000_0001
`define AFG_GROUP_CAP 32'h0000_0000
`define AFG_POWER_LEVELS 32'hC000_0009
`define AFG_LINK_CLK_CAPS 32'h0000_0018
`define AFG_CLK_96_BIT 4
`define AFG_CLK_48_BIT 3
`define AFG_CLK_RESET 6'h10
`define AFG_CLK_LEGAL 6'h18
`define AFG_PWR_D0 2'h0
`define AFG_PWR_D3 2'h3
`define AFG_PWR_RESET 2'h3
`define AFG_PWR_CLOCK_STOP_OK 32'h0000_0200
`define AFG_SSID_RESET 32'h0000_0000
`define AFG_RESP_ZERO 32'h0000_0000
`endif

// file: verilog/afg_edge_sync.v
// Two-stage synchroniser with rising-edge pulse for the link clock pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module afg_edge_sync (
  input wire clk,
  input wire reset,
  input wire pinIn,
  output reg pinLevel,
  output wire risePulse
);
  reg stage1_reg;
  reg prev_reg;
  always @(posedge clk) begin
    if (reset) begin
      stage1_reg <= 1'b0;
      pinLevel <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      stage1_reg <= pinIn;
      pinLevel <= stage1_reg;
      prev_reg <= pinLevel;
    end
  end
  assign risePulse = pinLevel & ~prev_reg;
endmodule // afg_edge_sync

// file: sim/afg_verb_monitor.sv
// Port checker for the verb responder.
// Assumes it is bound to afg_verb_responder.
`timescale 1ns/1ps
module afg_verb_monitor (
  input wire clk,
  input wire reset,
  input wire verbValid,
  input wire [7:0] verbNode,
  input wire [11:0] verbCode,
  input wire respValid,
  input wire [31:0] respData,
  input wire [1:0] actualPowerLevel,
  input wire [5:0] clockSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_resp_one_cycle: assert property (respValid |=> !respValid)
    else $error("resp too long");
  // Two sync flops sit between the request and the answer
  a_resp_after_verb: assert property (respValid |-> verbValid && $past(verbValid, 2))
    else $error("resp without verb");
  a_data_holds: assert property (!respValid |-> $stable(respData))
    else $error("resp data moved");
  a_pwr_legal: assert property (actualPowerLevel == 2'h0 || actualPowerLevel == 2'h3)
    else $error("bad power level");
  a_pwr_cause: assert property ($changed(actualPowerLevel) |-> verbValid && verbCode == 12'h705)
    else $error("power moved alone");
  a_clk_legal: assert property (clockSelect == 6'h10 || clockSelect == 6'h08)
    else $error("bad clock flags");
  a_reset_state: assert property ($fell(reset) |-> actualPowerLevel == 2'h3 && clockSelect == 6'h10)
    else $error("bad reset state");
  a_clk_report: assert property (respValid && verbNode == 8'h00 && verbCode == 12'hF37
    |-> respData == {26'h000_0000, clockSelect})
    else $error("clock report wrong");
endmodule // afg_verb_monitor
bind afg_verb_responder afg_verb_monitor u_mon (.clk, .reset, .verbValid, .verbNode,
  .verbCode, .respValid, .respData, .actualPowerLevel, .clockSelect);

// file: sim/afg_link_ctl.sv
// Link controller model: free-running link clock, one verb at a time.
// Assumes the bench calls send from a single thread.
`timescale 1ns/1ps
module afg_link_ctl (
  input wire clk,
  input wire respValid,
  input wire [31:0] respData,
  output reg linkClk,
  output reg verbValid,
  output reg [27:0] verbFields
);
  initial begin
    verbValid = 1'b0;
    verbFields = 28'h000_0000;
    linkClk = 1'b0;
    forever #100 linkClk = ~linkClk;
  end
  task send(input [27:0] f, output [31:0] r, output ok);
    integer i;
    begin
      @(posedge clk);
      #1 verbFields = f;
      // Fields must be seen at a link clock rise before the request
      repeat (12) @(posedge clk);
      #1 verbValid = 1'b1;
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i = i + 1) begin
        @(posedge clk);
        ok = (respValid === 1'b1);
      end
      r = respData;
      #1 verbValid = 1'b0;
      verbFields = ~f;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // afg_link_ctl

// file: sim/test_audio_codec_function_group_verbs.sv
// Self-checking bench comparing the responder with an integer model.
// Assumes the link controller model issues every verb.
`timescale 1ns/1ps
module test_audio_codec_function_group_verbs;
  reg clk, reset, ok;
  reg [31:0] seed, r, ssid;
  reg [39:0] prm = {8'h16, 8'h0F, 8'h08, 8'h05, 8'h04};
  reg [159:0] pexp = {32'h0000_0018, 32'hC000_0009, 32'h0000_0000, 32'h0000_0001, 32'h0003_0007};
  reg [31:0] clkList = {8'h08, 8'h20, 8'h10, 8'h08};
  wire linkClk, verbValid, respValid;
  wire [27:0] verbFields;
  wire [31:0] respData;
  wire [1:0] actualPowerLevel;
  wire [5:0] clockSelect;
  integer fail_count, n_compared, i, pReq, pAct, clkF;
  afg_verb_responder u_dut (.clk, .reset, .linkClk, .verbValid, .verbNode(verbFields[27:20]),
    .verbCode(verbFields[19:8]), .verbPayload(verbFields[7:0]), .respValid, .respData,
    .actualPowerLevel, .clockSelect);
  afg_link_ctl u_ctl (.clk, .respValid, .respData, .linkClk, .verbValid, .verbFields);
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task verb(input [27:0] f);
    begin
      u_ctl.send(f, r, ok);
      check("answer", ok, 1);
      if (!ok)
        give_verdict;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    fail_count = 0;
    n_compared = 0;
    seed = 32'hddf1_751d;
    {pReq, pAct, clkF, ssid} = {32'd3, 32'd3, 32'd16, 32'd0};
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    verb({8'h00, 12'hF00, 8'h04});
    check("rootcnt", r & 32'hFF00_FFFF, 32'h0000_0001);
    verb({8'h00, 12'hF37, 8'h00});
    check("rootclk", r, clkF);
    verb({8'h02, 12'hF00, 8'h04});
    check("badnode", r, 0);
    $display("test root done");
    for (i = 0; i < 5; i = i + 1) begin
      verb({8'h01, 12'hF00, prm[8*i +: 8]});
      check("param", r, pexp[32*i +: 32]);
    end
    $display("test params done");
    for (i = 0; i < 6; i = i + 1) begin
      if (i > 0)
        verb({8'h01, 12'h705, 6'h00, i[1:0]});
      // Only D0 (00) and D3 (11) are taken; 01 and 10 leave both levels alone
      if (i > 0 && i % 4 % 3 == 0)
        {pReq, pAct} = {i % 4, i % 4};
      verb({8'h01, 12'hF05, 8'h00});
      check("getpwr", r, 32'h0000_0200 | pAct << 4 | pReq);
      check("actpwr", actualPowerLevel, pAct);
    end
    $display("test power done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      if (i < 4)
        ssid[8*i +: 8] = seed[7:0];
      verb({8'h01, (i < 4) ? 12'h720 + i[11:0] : 12'hF1C + i[11:0], seed[7:0]});
      if (i > 3)
        check("ssid", r, ssid);
    end
    $display("test ssid done");
    for (i = 0; i < 4; i = i + 1) begin
      verb({8'h01, 12'h724, clkList[8*i +: 8]});
      if (clkList[8*i +: 8] == 8'h08 || clkList[8*i +: 8] == 8'h10)
        clkF = clkList[8*i +: 8];
      verb({8'h01, 12'hF24, 8'h00});
      check("getclk", r, clkF);
      check("clksel", clockSelect, clkF);
    end
    $display("test clock done");
    // Mid-run reset must restore D3 and the 96 MHz flag after both were moved
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    verb({8'h01, 12'hF05, 8'h00});
    check("rstpwr", r, 32'h0000_0233);
    check("rstact", actualPowerLevel, 3);
    verb({8'h01, 12'hF24, 8'h00});
    check("rstclk", r, 32'h0000_0010);
    $display("test reset done");
    give_verdict;
  end
endmodule // test_audio_codec_function_group_verbs
